/* hw/ocfr_pkg.sv */
// constants, encodings and carriers for the overcurrent fault response block
package ocfr_pkg;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int MS_CYCLES     = CLK_HZ / MS_PER_S;
   localparam int DELAY_UNIT_MS = 16;

   // ----------------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_PAGE         = 8'h00;
   localparam logic [7:0] CMD_OPERATION    = 8'h01;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OC_RESP      = 8'h47;
   localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
   localparam logic [7:0] CMD_STATUS_IOUT  = 8'h7b;
   localparam logic [7:0] CMD_DIE_OT_RESP  = 8'hd6;

   // ----------------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] OC_RESP_RST     = 8'h00;
   localparam logic [7:0] DIE_OT_RESP_RST = 8'hc0;
   localparam logic [7:0] PAGE_RST        = 8'h00;
   localparam logic [7:0] PAGE_ALL        = 8'hff;
   localparam logic [7:0] OP_RST          = 8'h80;
   localparam logic [7:0] UNMAPPED_RD     = 8'h00;
   localparam int         OP_ON_BIT       = 7;
   localparam int         SB_IOUT_OC_BIT  = 4;
   localparam int         SW_IOUT_BIT     = 14;
   localparam int         SI_OC_FAULT_BIT = 7;
   localparam logic [2:0] RETRY_FOREVER   = 3'b111;
   localparam logic [3:0] BYTE_END        = 4'h8;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      RESP_LIMIT    = 2'b00,
      RESP_UNSUP    = 2'b01,
      RESP_DEGLITCH = 2'b10,
      RESP_SHUTDOWN = 2'b11
   } ocfr_code_e;

   typedef struct packed {
      ocfr_code_e code;
      logic [2:0] retry;
      logic [2:0] delay;
   } ocfr_resp_s;

   typedef struct packed {
      logic channel_run_pin;
      logic oc_detect;
      logic other_fault;
   } ocfr_chin_s;

   typedef struct packed {
      logic out_en;
      logic cur_limit;
   } ocfr_chout_s;

   typedef enum {CH_OFF, CH_RUN, CH_LIMIT, CH_LATCH, CH_RETRY} ocfr_ch_e;

   typedef enum {
      BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
      BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
   } ocfr_bus_e;

endpackage

/* hw/ocfr_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module ocfr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // ocfr_sync

/* hw/ocfr_tick.sv */
// one-cycle pulse every CYC clocks, the millisecond time base
`timescale 1ns/1ns
module ocfr_tick #(
   parameter int CYC = 50000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pulse
   output logic      tick
);
   localparam int CW = $clog2(CYC);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   logic [CW-1:0] cnt_q, cnt_d;
   logic          tick_d;

   always_comb begin
      tick_d = (cnt_q == LAST);
      cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule // ocfr_tick

/* hw/ocfr_top.sv */
// overcurrent fault response: command slave, status and per-channel response
`timescale 1ns/1ns
module ocfr_top #(
   parameter int         NUM_CH    = 2,
   parameter int         CHW       = 1,
   parameter int         RI_W      = 16,
   parameter int         MS_CYCLES = ocfr_pkg::MS_CYCLES,
   parameter logic [6:0] DEV_ADDR  = 7'h4f  // arbitrary value
) (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   // management link
   input  wire logic                                  scl,
   input  wire logic                                  sda_i,
   output logic                                       sda_o,
   output logic                                       sda_oe,
   output logic                                       alert_o,
   output logic                                       alert_oe,
   // channel pins and settings
   input  wire ocfr_pkg::ocfr_chin_s [NUM_CH-1:0]     ch_in,
   input  wire logic [NUM_CH-1:0]                     oc_alert_mask,
   input  wire logic [NUM_CH-1:0][RI_W-1:0]           retry_interval_setting,
   // power stage control
   output ocfr_pkg::ocfr_chout_s [NUM_CH-1:0]         ch_out
);
   import ocfr_pkg::*;

   // ----------------------------------------------------------------------
   // synchronisers and edges
   // ----------------------------------------------------------------------
   localparam int SW = 2 + 3 * NUM_CH;

   logic [SW-1:0]           syn;
   logic                    scl_s, sda_s, scl_p_q, sda_p_q;
   ocfr_chin_s [NUM_CH-1:0] ch_s;
   logic                    ms_tick;
   logic                    start, stop, scl_rise, scl_fall;

   ocfr_sync #(.W(SW)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({~scl, ~sda_i, ch_in}),
      .q   (syn)
   );

   ocfr_tick #(.CYC(MS_CYCLES)) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (ms_tick)
   );

   // link pins idle high: stored inverted so the cleared pipe reads idle, no false edge
   assign scl_s    = ~syn[SW-1];
   assign sda_s    = ~syn[SW-2];
   assign ch_s     = syn[3*NUM_CH-1:0];
   assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic page_hit(input logic [7:0] pg, input int c);
      return (pg == PAGE_ALL) || (pg == 8'(c));
   endfunction

   // shutdown leads to endless retry only for the all-ones setting
   function automatic ocfr_ch_e after_shut(input logic [2:0] retry);
      return (retry == RETRY_FOREVER) ? CH_RETRY : CH_LATCH;
   endfunction

   function automatic logic [1:0] idx_inc(input logic [1:0] i);
      return (i == 2'h3) ? i : i + 2'h1;
   endfunction

   // ----------------------------------------------------------------------
   // command slave
   // ----------------------------------------------------------------------
   ocfr_bus_e                bus_q, bus_d;
   logic [3:0]               bit_q, bit_d;
   logic [7:0]               sh_q, sh_d, cmd_q, cmd_d, page_q, page_d;
   logic                     rw_q, rw_d, oe_d, clr_q, clr_d;
   logic [1:0]               idx_q, idx_d, rd_idx;
   logic [NUM_CH-1:0][7:0]   op_q, op_d;
   ocfr_resp_s [NUM_CH-1:0]  resp_q, resp_d;
   logic [NUM_CH-1:0]        oc_st_q, oc_st_d;
   logic [CHW-1:0]           rd_ch;
   logic [15:0]              sw;
   logic [7:0]               tx_byte;

   // read data, unpaged die response does not look at the page
   always_comb begin
      rd_ch  = (page_q < 8'(NUM_CH)) ? page_q[CHW-1:0] : '0;
      rd_idx = (bus_q == BUS_RDATA_ACK) ? idx_inc(idx_q) :
               (bus_q == BUS_ADDR_ACK)  ? 2'h0 : idx_q;
      sw     = '0;
      sw[SW_IOUT_BIT]    = oc_st_q[rd_ch];
      sw[SB_IOUT_OC_BIT] = oc_st_q[rd_ch];
      case (cmd_q)
         CMD_PAGE:        tx_byte = page_q;
         CMD_OPERATION:   tx_byte = op_q[rd_ch];
         CMD_OC_RESP:     tx_byte = resp_q[rd_ch];
         CMD_DIE_OT_RESP: tx_byte = DIE_OT_RESP_RST;
         CMD_STATUS_BYTE: tx_byte = sw[7:0];
         CMD_STATUS_WORD: tx_byte = (rd_idx == 2'h0) ? sw[7:0] :
                                    (rd_idx == 2'h1) ? sw[15:8] : UNMAPPED_RD;
         CMD_STATUS_IOUT: tx_byte = 8'(oc_st_q[rd_ch]) << SI_OC_FAULT_BIT;
         default:         tx_byte = UNMAPPED_RD;
      endcase
   end

   always_comb begin
      bus_d  = bus_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      cmd_d  = cmd_q;
      rw_d   = rw_q;
      idx_d  = idx_q;
      oe_d   = sda_oe;
      clr_d  = 1'b0;
      page_d = page_q;
      op_d   = op_q;
      resp_d = resp_q;
      if (start) begin
         bus_d = BUS_ADDR;
         bit_d = '0;
         oe_d  = 1'b0;
      end else if (stop) begin
         bus_d = BUS_IDLE;
         oe_d  = 1'b0;
      end else if (scl_rise) begin
         case (bus_q)
            BUS_ADDR, BUS_CMD, BUS_WDATA: begin
               sh_d  = {sh_q[6:0], sda_s};
               bit_d = bit_q + 4'h1;
            end
            BUS_RDATA:     bit_d = bit_q + 4'h1;
            // host not-acknowledge ends the read
            BUS_RDATA_ACK: if (sda_s) bus_d = BUS_IDLE;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (bus_q)
            BUS_ADDR: if (bit_q == BYTE_END) begin
               if (sh_q[7:1] == DEV_ADDR) begin
                  oe_d  = 1'b1;
                  rw_d  = sh_q[0];
                  bus_d = BUS_ADDR_ACK;
               end else begin
                  bus_d = BUS_IDLE;
               end
            end
            BUS_ADDR_ACK: begin
               bit_d = '0;
               idx_d = '0;
               if (rw_q) begin
                  sh_d  = tx_byte;
                  oe_d  = ~tx_byte[7];
                  bus_d = BUS_RDATA;
               end else begin
                  oe_d  = 1'b0;
                  bus_d = BUS_CMD;
               end
            end
            BUS_CMD: if (bit_q == BYTE_END) begin
               oe_d  = 1'b1;
               cmd_d = sh_q;
               idx_d = '0;
               clr_d = (sh_q == CMD_CLEAR_FAULTS);
               bus_d = BUS_CMD_ACK;
            end
            BUS_CMD_ACK, BUS_WDATA_ACK: begin
               oe_d  = 1'b0;
               bit_d = '0;
               bus_d = BUS_WDATA;
            end
            BUS_WDATA: if (bit_q == BYTE_END) begin
               oe_d  = 1'b1;
               idx_d = idx_inc(idx_q);
               bus_d = BUS_WDATA_ACK;
               // only the first byte after the command is data; extras are dropped
               if (idx_q == 2'h0) begin
                  if (cmd_q == CMD_PAGE) page_d = sh_q;
                  for (int c = 0; c < NUM_CH; c++) begin
                     if (page_hit(page_q, c) && cmd_q == CMD_OPERATION) op_d[c] = sh_q;
                     if (page_hit(page_q, c) && cmd_q == CMD_OC_RESP) begin
                        resp_d[c] = ocfr_resp_s'(sh_q);
                     end
                  end
               end
            end
            BUS_RDATA: if (bit_q == BYTE_END) begin
               oe_d  = 1'b0;
               bus_d = BUS_RDATA_ACK;
            end else begin
               sh_d = {sh_q[6:0], 1'b0};
               oe_d = ~sh_q[6];
            end
            BUS_RDATA_ACK: begin
               bit_d = '0;
               idx_d = idx_inc(idx_q);
               sh_d  = tx_byte;
               oe_d  = ~tx_byte[7];
               bus_d = BUS_RDATA;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         bus_q   <= BUS_IDLE;
         bit_q   <= '0;
         sh_q    <= '0;
         cmd_q   <= '0;
         rw_q    <= 1'b0;
         idx_q   <= '0;
         sda_oe  <= 1'b0;
         sda_o   <= 1'b0;
         clr_q   <= 1'b0;
         page_q  <= PAGE_RST;
         op_q    <= {NUM_CH{OP_RST}};
         resp_q  <= {NUM_CH{OC_RESP_RST}};
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         bus_q   <= bus_d;
         bit_q   <= bit_d;
         sh_q    <= sh_d;
         cmd_q   <= cmd_d;
         rw_q    <= rw_d;
         idx_q   <= idx_d;
         sda_oe  <= oe_d;
         sda_o   <= 1'b0;
         clr_q   <= clr_d;
         page_q  <= page_d;
         op_q    <= op_d;
         resp_q  <= resp_d;
      end
   end

   // ----------------------------------------------------------------------
   // per-channel fault response
   // ----------------------------------------------------------------------
   ocfr_ch_e                 ch_q [NUM_CH];
   ocfr_ch_e                 ch_d [NUM_CH];
   logic [NUM_CH-1:0][15:0]  tmr_q, tmr_d;
   logic [NUM_CH-1:0]        run_p_q, run_d;
   ocfr_chout_s [NUM_CH-1:0] out_d;
   logic                     alert_d;

   // timers count whole milliseconds, so a delay may fall up to 1 ms short
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         run_d[c] = ch_s[c].channel_run_pin & op_q[c][OP_ON_BIT];
         ch_d[c]  = ch_q[c];
         tmr_d[c] = (ms_tick && tmr_q[c] != 16'h0) ? tmr_q[c] - 16'h1 : tmr_q[c];
         case (ch_q[c])
            CH_OFF: if (run_d[c] && !ch_s[c].other_fault) ch_d[c] = CH_RUN;
            CH_RUN, CH_LIMIT: begin
               if (!run_d[c]) begin
                  ch_d[c] = CH_OFF;
               end else if (ch_s[c].other_fault) begin
                  ch_d[c] = CH_LATCH;
               end else if (ch_s[c].oc_detect) begin
                  case (resp_q[c].code)
                     RESP_SHUTDOWN: begin
                        ch_d[c]  = after_shut(resp_q[c].retry);
                        tmr_d[c] = 16'(retry_interval_setting[c]);
                     end
                     RESP_DEGLITCH: begin
                        if (ch_q[c] == CH_RUN) begin
                           ch_d[c]  = CH_LIMIT;
                           tmr_d[c] = 16'(resp_q[c].delay) * 16'(DELAY_UNIT_MS);
                        end else if (tmr_q[c] == 16'h0) begin
                           ch_d[c]  = after_shut(resp_q[c].retry);
                           tmr_d[c] = 16'(retry_interval_setting[c]);
                        end
                     end
                     // unsupported code falls back to plain limiting; delay unused
                     default: ch_d[c] = CH_LIMIT;
                  endcase
               end else begin
                  ch_d[c] = CH_RUN;
               end
            end
            // only dropping the run pin releases a latched shutdown
            CH_LATCH: if (!ch_s[c].channel_run_pin) ch_d[c] = CH_OFF;
            CH_RETRY: begin
               if (!run_d[c]) ch_d[c] = CH_OFF;
               else if (ch_s[c].other_fault) ch_d[c] = CH_LATCH;
               else if (tmr_q[c] == 16'h0) ch_d[c] = CH_RUN;
            end
            default: ch_d[c] = CH_OFF;
         endcase
         out_d[c].out_en    = (ch_d[c] == CH_RUN) || (ch_d[c] == CH_LIMIT);
         out_d[c].cur_limit = (ch_d[c] == CH_LIMIT);
         // a new fault in the clearing cycle survives the clear
         oc_st_d[c] = (oc_st_q[c] & ~(clr_q | (run_d[c] & ~run_p_q[c])))
                    | (ch_s[c].oc_detect & (ch_q[c] == CH_RUN || ch_q[c] == CH_LIMIT));
      end
      alert_d = |(oc_st_d & ~oc_alert_mask);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NUM_CH; c++) ch_q[c] <= CH_OFF;
         tmr_q    <= '0;
         run_p_q  <= '0;
         oc_st_q  <= '0;
         ch_out   <= '0;
         alert_oe <= 1'b0;
         alert_o  <= 1'b0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) ch_q[c] <= ch_d[c];
         tmr_q    <= tmr_d;
         run_p_q  <= run_d;
         oc_st_q  <= oc_st_d;
         ch_out   <= out_d;
         alert_oe <= alert_d;
         alert_o  <= 1'b0;
      end
   end
endmodule // ocfr_top

/* testbench/ocfr_sva.sv */
// port assertions for the overcurrent fault response block
`timescale 1ns/1ns
module ocfr_sva #(
   parameter int NUM_CH = 2
) (
   // clock and reset
   input wire logic                                clk,
   input wire logic                                rst,
   // link pins
   input wire logic                                sda_o,
   input wire logic                                alert_o,
   input wire logic                                alert_oe,
   // channels
   input wire ocfr_pkg::ocfr_chin_s [NUM_CH-1:0]   ch_in,
   input wire logic [NUM_CH-1:0]                   oc_alert_mask,
   input wire ocfr_pkg::ocfr_chout_s [NUM_CH-1:0]  ch_out
);
   import ocfr_pkg::*;
   // ----------
   // port checks, per-channel ones on channel 0 only
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // unmasked overcurrent held long enough to pass the pin synchroniser
   sequence oc_seen;
      !oc_alert_mask[0] && ch_out[0].out_en ##0 $rose(ch_in[0].oc_detect)
         ##1 ch_in[0].oc_detect [*4];
   endsequence
   sequence other_held;
      ch_in[0].other_fault [*6];
   endsequence

   oc_alert_a: assert property (oc_seen |-> ##[0:2] alert_oe)
      else $error("overcurrent did not raise alert");
   alert_mask_a: assert property (
      $rose(alert_oe) |-> !(&$past(oc_alert_mask)))
      else $error("alert rose with all sources masked");
   open_drain_a: assert property (!sda_o && !alert_o)
      else $error("open drain pin driven high");
   limit_src_a: assert property (
      $rose(ch_out[0].cur_limit) |-> $past(ch_in[0].oc_detect, 3))
      else $error("current limit without overcurrent");
   limit_end_a: assert property (!ch_in[0].oc_detect [*6] |-> !ch_out[0].cur_limit)
      else $error("current limit outlived overcurrent");
   limit_on_a: assert property (ch_out[0].cur_limit |-> ch_out[0].out_en)
      else $error("current limit while output off");
   shut_cause_a: assert property (
      $fell(ch_out[0].out_en) |-> $past(ch_in[0].oc_detect, 3)
         || $past(ch_in[0].other_fault, 3) || !$past(ch_in[0].channel_run_pin, 3))
      else $error("output dropped without cause");
   restart_a: assert property (
      $rose(ch_out[0].out_en) |-> $past(ch_in[0].channel_run_pin, 3)
         && !$past(ch_in[0].other_fault, 3))
      else $error("output restarted while off or faulted");
   other_off_a: assert property (other_held |-> !ch_out[0].out_en)
      else $error("output on during other fault");
   reset_a: assert property ($fell(rst) |-> ch_out == '0 && !alert_oe)
      else $error("outputs not idle after reset");
endmodule // ocfr_sva

bind ocfr_top ocfr_sva #(.NUM_CH(NUM_CH)) u_ocfr_sva (
   .clk(clk), .rst(rst), .sda_o(sda_o), .alert_o(alert_o), .alert_oe(alert_oe),
   .ch_in(ch_in), .oc_alert_mask(oc_alert_mask), .ch_out(ch_out)
);

/* testbench/ocfr_host.sv */
// management link host model, open drain on the data line
`timescale 1ns/1ns
module ocfr_host (
   // link pins
   output logic      scl,
   output logic      sda_dn,
   input  wire logic sda
);
   // ----------
   // bit, frame and transaction tasks
   // ----------
   initial begin
      scl = 1'b1;
      sda_dn = 1'b0;
   end
   // data moves mid low phase; 160 ns bit leaves 2 clocks each side
   task automatic bit_io(input logic b, output logic s);
      sda_dn = !b;
      #40 scl = 1'b1;
      #40 s = sda;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic frame(input logic [7:0] w, input logic b9, output logic [7:0] r,
                        output logic s9);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(b9, s9);
   endtask
   // long release before scl rises: the slave may still hold its ack
   task automatic start();
      sda_dn = 1'b0;
      #80 scl = 1'b1;
      #80 sda_dn = 1'b1;
      #80 scl = 1'b0;
      #40;
   endtask
   task automatic stop();
      sda_dn = 1'b1;
      #40 scl = 1'b1;
      #80 sda_dn = 1'b0;
      #80;
   endtask
   task automatic op(input logic [6:0] a, input logic [7:0] c, input int nw,
                     input logic [7:0] d, input int nr, output logic [15:0] r,
                     output logic nak);
      logic [7:0] x;
      logic       s;
      r = 16'h0;
      start();
      frame({a, 1'b0}, 1'b1, x, s);
      nak = s;
      if (!nak) begin
         frame(c, 1'b1, x, s);
         nak = s;
         for (int i = 0; i < nw; i++) begin
            frame(d, 1'b1, x, s);
            nak = nak | s;
         end
         if (nr > 0) begin
            start();
            frame({a, 1'b1}, 1'b1, x, s);
            nak = nak | s;
            for (int i = 0; i < nr; i++) begin
               frame(8'hff, i == nr - 1, x, s);
               r[8*i +: 8] = x;
            end
         end
      end
      stop();
   endtask
endmodule // ocfr_host

/* testbench/tb.sv */
// self-checking bench for the overcurrent fault response block
`timescale 1ns/1ns
module tb;
   import ocfr_pkg::*;
   // ----------
   // design, host and wiring
   // ----------
   localparam int         MSC = 20;
   localparam logic [6:0] DEV = 7'h4f;
   logic                    clk;
   logic                    rst;
   logic                    scl;
   logic                    sda;
   logic                    sda_dn;
   logic                    sda_oe;
   logic                    alert_oe;
   ocfr_chin_s  [1:0]       ch_in;
   ocfr_chout_s [1:0]       ch_out;
   logic        [1:0]       mask;
   logic        [1:0][15:0] ri_set;
   logic        [15:0]      got_v;
   logic        [15:0]      exp_v;
   logic        [15:0]      exp_q[$];
   logic        [15:0]      r;
   logic                    nk;
   event                    got_ev;
   int                      err_count;
   int                      comparisons;
   int                      cycles;
   int                      seed = 99696;
   int                      ri;
   int                      n;

   assign sda = !(sda_dn || sda_oe);
   ocfr_top #(.MS_CYCLES(MSC)) u_ocfr_top (
      .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .alert_o(), .alert_oe(alert_oe), .ch_in(ch_in), .oc_alert_mask(mask),
      .retry_interval_setting(ri_set), .ch_out(ch_out)
   );
   ocfr_host u_ocfr_host (.scl(scl), .sda_dn(sda_dn), .sda(sda));

   // ----------
   // clock, watchdog and result monitor
   // ----------
   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   initial begin
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == 40000) begin
            err_count++;
            $display("Error %0t: watchdog expired", $time);
            end_of_test();
         end
      end
   end
   initial begin
      forever begin
         @(got_ev);
         comparisons++;
         exp_v = exp_q.pop_front();
         if (got_v !== exp_v) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got_v, exp_v);
         end
      end
   end

   // ----------
   // tasks
   // ----------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic obs(input logic [15:0] g, input logic [15:0] e);
      exp_q.push_back(e);
      got_v = g;
      -> got_ev;
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input int nw);
      logic [15:0] q;
      logic        k;
      cyc(1);
      u_ocfr_host.op(DEV, c, nw, d, 0, q, k);
      obs({15'h0, k}, 16'h0);
   endtask
   task automatic rd(input logic [7:0] c, input int nr, input logic [15:0] e);
      logic [15:0] q;
      logic        k;
      cyc(1);
      u_ocfr_host.op(DEV, c, 0, 8'h00, nr, q, k);
      obs(q, e);
   endtask
   // {alert, out_en, cur_limit} of channel 0
   task automatic pin(input logic [2:0] e);
      obs({13'h0, alert_oe, ch_out[0]}, {13'h0, e});
   endtask
   // {run, oc, other} of channel 0
   task automatic setin(input logic [2:0] v);
      cyc(1);
      ch_in[0] = ocfr_chin_s'(v);
      cyc(10);
   endtask

   // ----------
   // main sequence
   // ----------
   initial begin
      rst = 1'b1;
      ch_in = '0;
      ch_in[0].channel_run_pin = 1'b1;
      ch_in[1].channel_run_pin = 1'b1;
      mask = 2'b00;
      ri = 3 + {$random(seed)} % 6;
      ri_set[0] = 16'(ri);
      ri_set[1] = 16'($random(seed));
      cyc(5);
      rst = 1'b0;
      cyc(10);
      rd(CMD_OC_RESP, 1, 16'h00);
      rd(CMD_DIE_OT_RESP, 1, 16'hc0);
      wr(CMD_DIE_OT_RESP, 8'h3c, 1);
      rd(CMD_DIE_OT_RESP, 1, 16'hc0);
      rd(8'h20, 1, 16'h00);
      cyc(1);
      u_ocfr_host.op(7'h11, CMD_OC_RESP, 1, 8'hff, 0, r, nk);
      obs({15'h0, nk}, 16'h1);
      wr(CMD_PAGE, 8'h01, 1);
      wr(CMD_OC_RESP, 8'hc5, 1);
      rd(CMD_OC_RESP, 1, 16'hc5);
      rd(CMD_DIE_OT_RESP, 1, 16'hc0);
      wr(CMD_PAGE, 8'h00, 1);
      rd(CMD_OC_RESP, 1, 16'h00);
      $display("done: registers");
      wr(CMD_OC_RESP, 8'h07, 1);
      cyc(1);
      mask = 2'b01;
      setin(3'b110);
      pin(3'b011);
      cyc(2400);
      pin(3'b011);
      rd(CMD_STATUS_BYTE, 1, 16'h0010);
      rd(CMD_STATUS_WORD, 2, 16'h4010);
      rd(CMD_STATUS_IOUT, 1, 16'h0080);
      setin(3'b100);
      pin(3'b010);
      rd(CMD_STATUS_BYTE, 1, 16'h0010);
      wr(CMD_CLEAR_FAULTS, 8'h00, 0);
      rd(CMD_STATUS_IOUT, 1, 16'h0000);
      cyc(1);
      mask = 2'b00;
      setin(3'b110);
      pin(3'b111);
      setin(3'b100);
      pin(3'b110);
      wr(CMD_CLEAR_FAULTS, 8'h00, 0);
      cyc(4);
      pin(3'b010);
      $display("done: limit code");
      wr(CMD_OC_RESP, 8'h81, 1);
      setin(3'b110);
      pin(3'b111);
      cyc(250);
      pin(3'b111);
      cyc(140);
      pin(3'b100);
      cyc(400);
      pin(3'b100);
      setin(3'b100);
      pin(3'b100);
      setin(3'b000);
      setin(3'b100);
      pin(3'b010);
      rd(CMD_STATUS_BYTE, 1, 16'h0000);
      $display("done: deglitch code");
      wr(CMD_OC_RESP, 8'hf8, 1);
      setin(3'b110);
      pin(3'b100);
      setin(3'b100);
      n = 0;
      while (ch_out[0].out_en !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      obs({15'h0, n + 17 >= (ri - 1) * MSC && n + 17 <= (ri + 1) * MSC}, 16'h1);
      setin(3'b101);
      obs({15'h0, ch_out[0].out_en}, 16'h0);
      cyc((ri + 3) * MSC);
      obs({15'h0, ch_out[0].out_en}, 16'h0);
      setin(3'b000);
      setin(3'b100);
      obs({15'h0, ch_out[0].out_en}, 16'h1);
      obs({14'h0, ch_out[1]}, 16'h2);
      cyc(1);
      ch_in[1].oc_detect = 1'b1;
      cyc(10);
      obs({14'h0, ch_out[1]}, 16'h0);
      $display("done: shutdown code");
      end_of_test();
   end
endmodule // tb
